//--- hdl/scd_cfg.svh
// Constants of the storage card command decoder
`ifndef SCD_CFG_SVH
`define SCD_CFG_SVH

// Task-file write offsets
`define SCD_TF_FEAT 3'h1
`define SCD_TF_SC 3'h2
`define SCD_TF_SN 3'h3
`define SCD_TF_CYL_LO 3'h4
`define SCD_TF_CYL_HI 3'h5
`define SCD_TF_DH 3'h6
`define SCD_TF_CMD 3'h7

// Status bit positions
`define SCD_BSY 7
`define SCD_RDY 6
`define SCD_DSC 4
`define SCD_DRQ 3
`define SCD_ERR 0

// Status and error values
`define SCD_ST_RESET 8'h00
`define SCD_ST_BUSY 8'h80
`define SCD_ST_DONE 8'h50
`define SCD_ST_DRQ 8'h58
`define SCD_ST_ABORT 8'h51
`define SCD_ERR_NONE 8'h00
`define SCD_ERR_ABRT 8'h04
`define SCD_DIAG_SLAVE_NIB 4'h8

// Power-mode query answers in sector count
`define SCD_PWR_SLEEP_SC 8'h00
`define SCD_PWR_IDLE_SC 8'hff

// Opcodes handled inside the decoder
`define SCD_OP_PWR_A 8'h98
`define SCD_OP_PWR_B 8'he5
`define SCD_OP_DIAG 8'h90

// Sector count zero means this many sectors
`define SCD_SC_ZERO_LEN 9'h100

// Drive/head field layout
`define SCD_DH_LBA 6
`define SCD_DH_DRV 4

// Parameter-use mask bit positions
`define SCD_PU_FR 0
`define SCD_PU_SC 1
`define SCD_PU_SN 2
`define SCD_PU_CY 3
`define SCD_PU_DH 4
`define SCD_PU_LBA 5

`endif

//--- hdl/scd_pkg.sv
// Types of the storage card command decoder
package scd_pkg;

    typedef enum logic [3:0] {
        SCD_IDLE = 4'b0001,
        SCD_DECODE = 4'b0010,
        SCD_EXEC = 4'b0100,
        SCD_DIAG = 4'b1000
    } scd_state_t;

    typedef struct packed {
        scd_state_t state;
        logic ready;
        logic [7:0] status;
        logic [7:0] error;
        logic [7:0] feat;
        logic [7:0] sc;
        logic [7:0] sn;
        logic [15:0] cyl;
        logic [7:0] dh;
        logic [7:0] opcode;
        logic irq;
        logic start;
        logic spec;
        logic [7:0] p_feat;
        logic [7:0] p_sc;
        logic [8:0] xlen;
        logic [7:0] p_sn;
        logic [15:0] p_cyl;
        logic p_drv;
        logic [3:0] p_head;
        logic lba;
        logic [5:0] mask;
    } scd_regs_t;

endpackage

//--- hdl/scd_op_class.sv
// Opcode classifier: support and parameter use per command
`timescale 1ns/100ps
`include "scd_cfg.svh"

module scd_op_class
    import scd_pkg::*;
(
    input wire logic [7:0] opcode,
    output logic supported,
    output logic [5:0] use_mask,
    output logic dh_full,
    output logic cmd_spec
);

    // Mask order is {lba, dh, cy, sn, sc, fr}
    always_comb begin
        supported = 1'b1;
        use_mask = 6'h10;
        dh_full = 1'b0;
        cmd_spec = 1'b0;
        casez (opcode)
            // Media access with full addressing
            8'hc0, 8'hc8, 8'hc4, 8'h20, 8'h21, 8'h40, 8'h41, 8'h87,
            8'hca, 8'hc5, 8'h30, 8'h31, 8'h3c: begin
                use_mask = 6'h3e;
                dh_full = 1'b1;
            end
            8'h38: begin
                use_mask = 6'h3e;
                dh_full = 1'b1;
            end
            8'hcd: begin
                use_mask = 6'h3e;
                dh_full = 1'b1;
            end
            // Format track ignores sector number
            8'h50: begin
                use_mask = 6'h3a;
                dh_full = 1'b1;
            end
            // Seek family ignores sector count
            8'h7?: begin
                use_mask = 6'h3c;
                dh_full = 1'b1;
            end
            // Init parameters takes the head count
            8'h91: begin
                use_mask = 6'h12;
                dh_full = 1'b1;
                cmd_spec = 1'b1;
            end
            8'he3, 8'h97, 8'hc6: begin
                use_mask = 6'h12;
                cmd_spec = 1'b1;
            end
            8'hef: begin
                use_mask = 6'h11;
                cmd_spec = 1'b1;
            end
            // Key management variants are optional and absent
            8'hb9: begin
                supported = 1'b0;
                use_mask = 6'h1f;
            end
            // Cache flush, no-op and long transfers are absent
            8'he7, 8'h00, 8'h22, 8'h23, 8'h32, 8'h33: begin
                supported = 1'b0;
            end
            // Drive-select-only commands
            8'he5, 8'h98, 8'h90, 8'hec, 8'he1, 8'h95, 8'he4, 8'h1?,
            8'h03, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'he6,
            8'h99, 8'he2, 8'h96, 8'he0, 8'h94, 8'he8: begin
                dh_full = 1'b0;
            end
            default: begin
                supported = 1'b0;
            end
        endcase
    end

endmodule

//--- hdl/scd_decoder.sv
// Command decoder and task-file interpreter of the storage card
`timescale 1ns/100ps
`include "scd_cfg.svh"

// What this block does
// - Decode opcodes, use only meaningful registers
// - Support write without erase opcode
// - Support multiple write without erase
// - Sector count zero means 256 sectors
// - Head number ranges 0 to 15
// - Full usage takes drive and head
// - Drive-only usage ignores head field
// - Command-specific registers passed for command
// - Unused task-file registers are ignored
// - Block addressing for capable opcodes
// - Key management variants are unsupported
// - Skipped command completes with 0x50
// - Power query: two opcodes, drive only
// - Asleep power query loads count zero
// - Idle power query loads count ones
// - Card mode diagnostic only when selected
// - Emulation mode diagnostic ignores drive bit
// - Emulation mode master reports combined diagnostic status
// - Diagnostic result code in error register
// - Slave failure reported as 8Xh
// - Status bit layout, busy masks others
// - Primary status read clears interrupt
// - Cache flush ends as aborted
module scd_decoder
    import scd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic tf_wr_stb,
    input wire logic [2:0] tf_wr_addr,
    input wire logic [7:0] tf_wr_data,
    input wire logic status_rd_stb,
    input wire logic alt_status_rd_stb,
    input wire logic disk_emulation_mode,
    input wire logic card_drive_id,
    input wire logic is_master,
    input wire logic power_sleep,
    input wire logic skip_en,
    input wire logic [7:0] skip_opcode,
    input wire logic exec_done,
    input wire logic exec_drq,
    input wire logic exec_err,
    input wire logic [7:0] exec_err_code,
    input wire logic diag_done,
    input wire logic [7:0] diag_self_code,
    input wire logic slave_diag_fail,
    output logic [7:0] status_q,
    output logic [7:0] error_q,
    output logic [7:0] sector_count_field_q,
    output logic irq_q,
    output logic cmd_start_q,
    output logic [7:0] cmd_opcode_q,
    output logic cmd_spec_q,
    output logic [7:0] prm_feature_q,
    output logic [7:0] prm_sector_count_q,
    output logic [8:0] xfer_len_q,
    output logic [7:0] prm_sector_number_q,
    output logic [15:0] prm_cylinder_q,
    output logic prm_drive_q,
    output logic [3:0] prm_head_q,
    output logic lba_mode_q,
    output logic [5:0] use_mask_q
);

    scd_regs_t s_q;
    scd_regs_t s_d;
    logic cls_sup;
    logic [5:0] cls_mask;
    logic cls_dh_full;
    logic cls_spec;
    logic sel;
    logic is_pwr;
    logic is_diag;
    logic skip_hit;
    logic wr_ok;
    logic done_set;
    logic [8:0] xlen_calc;
    logic [7:0] diag_code;

    // Table lookup on the latched opcode
    scd_op_class u_cls (
        .opcode(s_q.opcode),
        .supported(cls_sup),
        .use_mask(cls_mask),
        .dh_full(cls_dh_full),
        .cmd_spec(cls_spec)
    );

    // Decode helpers on the latched task file
    assign sel = (s_q.dh[`SCD_DH_DRV] == card_drive_id);
    assign is_pwr = (s_q.opcode == `SCD_OP_PWR_A) || (s_q.opcode == `SCD_OP_PWR_B);
    assign is_diag = (s_q.opcode == `SCD_OP_DIAG);
    assign skip_hit = skip_en && (s_q.opcode == skip_opcode);
    // Writes are dropped while busy or working; the host keeps off anyway
    assign wr_ok = tf_wr_stb && s_q.ready && (s_q.state == SCD_IDLE);
    assign xlen_calc = (s_q.sc == 8'h00) ? `SCD_SC_ZERO_LEN : {1'b0, s_q.sc};

    // In emulation mode the master folds a failing slave into the upper nibble
    always_comb begin
        diag_code = diag_self_code;
        if (disk_emulation_mode && is_master && slave_diag_fail) begin
            diag_code = {`SCD_DIAG_SLAVE_NIB, diag_self_code[3:0]};
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        done_set = 1'b0;
        // Ready comes up one cycle after reset release
        if (!s_q.ready) begin
            s_d.ready = 1'b1;
            s_d.status = `SCD_ST_DONE;
        end
        // Task-file writes
        if (wr_ok) begin
            if (tf_wr_addr == `SCD_TF_FEAT) begin
                s_d.feat = tf_wr_data;
            end else if (tf_wr_addr == `SCD_TF_SC) begin
                s_d.sc = tf_wr_data;
            end else if (tf_wr_addr == `SCD_TF_SN) begin
                s_d.sn = tf_wr_data;
            end else if (tf_wr_addr == `SCD_TF_CYL_LO) begin
                s_d.cyl[7:0] = tf_wr_data;
            end else if (tf_wr_addr == `SCD_TF_CYL_HI) begin
                s_d.cyl[15:8] = tf_wr_data;
            end else if (tf_wr_addr == `SCD_TF_DH) begin
                s_d.dh = tf_wr_data;
            end else if (tf_wr_addr == `SCD_TF_CMD) begin
                s_d.opcode = tf_wr_data;
                s_d.status = `SCD_ST_BUSY;
                s_d.state = SCD_DECODE;
            end
        end
        case (s_q.state)
            SCD_DECODE: begin
                s_d.state = SCD_IDLE;
                s_d.status = `SCD_ST_DONE;
                if (is_diag) begin
                    if (disk_emulation_mode || sel) begin
                        s_d.state = SCD_DIAG;
                        s_d.status = `SCD_ST_BUSY;
                    end
                end else if (!sel) begin
                    // Another card owns this command; stay silent
                    s_d.status = `SCD_ST_DONE;
                end else if (skip_hit) begin
                    s_d.error = `SCD_ERR_NONE;
                    done_set = 1'b1;
                end else if (!cls_sup) begin
                    s_d.status = `SCD_ST_ABORT;
                    s_d.error = `SCD_ERR_ABRT;
                    done_set = 1'b1;
                end else if (is_pwr) begin
                    // Only the drive bit matters here
                    s_d.sc = power_sleep ? `SCD_PWR_SLEEP_SC : `SCD_PWR_IDLE_SC;
                    s_d.error = `SCD_ERR_NONE;
                    done_set = 1'b1;
                end else begin
                    // Capture only registers marked used
                    s_d.mask = cls_mask;
                    s_d.spec = cls_spec;
                    s_d.p_feat = cls_mask[`SCD_PU_FR] ? s_q.feat : 8'h00;
                    s_d.p_sc = cls_mask[`SCD_PU_SC] ? s_q.sc : 8'h00;
                    s_d.xlen = cls_mask[`SCD_PU_SC] ? xlen_calc : 9'h000;
                    s_d.p_sn = cls_mask[`SCD_PU_SN] ? s_q.sn : 8'h00;
                    s_d.p_cyl = cls_mask[`SCD_PU_CY] ? s_q.cyl : 16'h0000;
                    s_d.p_drv = s_q.dh[`SCD_DH_DRV];
                    s_d.p_head = cls_dh_full ? s_q.dh[3:0] : 4'h0;
                    s_d.lba = cls_mask[`SCD_PU_LBA] && s_q.dh[`SCD_DH_LBA];
                    s_d.start = 1'b1;
                    s_d.status = `SCD_ST_BUSY;
                    s_d.state = SCD_EXEC;
                end
            end
            SCD_EXEC: begin
                // Data request drops busy so the host may move data
                s_d.status = exec_drq ? `SCD_ST_DRQ : `SCD_ST_BUSY;
                if (exec_done) begin
                    s_d.status = exec_err ? `SCD_ST_ABORT : `SCD_ST_DONE;
                    s_d.error = exec_err ? exec_err_code : `SCD_ERR_NONE;
                    done_set = 1'b1;
                    s_d.state = SCD_IDLE;
                end
            end
            SCD_DIAG: begin
                if (diag_done) begin
                    s_d.error = diag_code;
                    s_d.status = `SCD_ST_DONE;
                    done_set = 1'b1;
                    s_d.state = SCD_IDLE;
                end
            end
            // Idle keeps the state chosen by a command write
            SCD_IDLE: begin
            end
            default: begin
                s_d.state = SCD_IDLE;
            end
        endcase
        // Alternate status read leaves the pending flag alone
        if (status_rd_stb) begin
            s_d.irq = 1'b0;
        end
        // A completion in the same cycle as the read wins
        if (done_set) begin
            s_d.irq = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{state: SCD_IDLE, status: `SCD_ST_RESET, error: `SCD_ERR_NONE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign status_q = s_q.status;
    assign error_q = s_q.error;
    assign sector_count_field_q = s_q.sc;
    assign irq_q = s_q.irq;
    assign cmd_start_q = s_q.start;
    assign cmd_opcode_q = s_q.opcode;
    assign cmd_spec_q = s_q.spec;
    assign prm_feature_q = s_q.p_feat;
    assign prm_sector_count_q = s_q.p_sc;
    assign xfer_len_q = s_q.xlen;
    assign prm_sector_number_q = s_q.p_sn;
    assign prm_cylinder_q = s_q.p_cyl;
    assign prm_drive_q = s_q.p_drv;
    assign prm_head_q = s_q.p_head;
    assign lba_mode_q = s_q.lba;
    assign use_mask_q = s_q.mask;

    // Checks on the decoder behaviour
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    sequence seq_decode_sel;
        (s_q.state == SCD_DECODE) && sel && !is_diag && !skip_hit;
    endsequence

    sequence seq_cmd_write;
        wr_ok && (tf_wr_addr == `SCD_TF_CMD);
    endsequence

    sequence seq_decode_skip;
        (s_q.state == SCD_DECODE) && sel && !is_diag && skip_hit;
    endsequence

    a_busy_masks_bits: assert property (status_q[`SCD_BSY] |-> status_q[6:0] == 7'h00)
        else $error("status bits valid while busy");

    a_cmd_sets_busy: assert property (seq_cmd_write |=> status_q == `SCD_ST_BUSY ##1 1'b1)
        else $error("command write did not raise busy");

    a_pwr_sleep_zero: assert property (seq_decode_sel ##0 (cls_sup && is_pwr && power_sleep)
        |=> (sector_count_field_q == `SCD_PWR_SLEEP_SC) && !status_q[`SCD_BSY] && irq_q)
        else $error("sleep power query answer wrong");

    a_pwr_idle_ones: assert property (seq_decode_sel ##0 (cls_sup && is_pwr && !power_sleep)
        |=> (sector_count_field_q == `SCD_PWR_IDLE_SC) && $past(status_q[`SCD_BSY]) && irq_q)
        else $error("idle power query answer wrong");

    a_abort_unknown: assert property (seq_decode_sel ##0 !cls_sup
        |=> status_q[`SCD_ERR] && (error_q == `SCD_ERR_ABRT) && irq_q && (s_q.state == SCD_IDLE))
        else $error("unsupported opcode not aborted");

    a_skip_done: assert property (seq_decode_skip
        |=> (error_q == `SCD_ERR_NONE) && (s_q.state == SCD_IDLE) && !cmd_start_q)
        else $error("skipped command did work");

    a_skip_value: assert property ((s_q.state == SCD_DECODE) && sel && !is_diag && skip_hit
        |=> (status_q == `SCD_ST_DONE) && irq_q && !cmd_start_q)
        else $error("skipped command status wrong");

    a_irq_clear_rd: assert property (irq_q && status_rd_stb && !done_set |=> !irq_q)
        else $error("status read did not clear interrupt");

    a_irq_alt_keep: assert property (irq_q && alt_status_rd_stb && !status_rd_stb |=> irq_q)
        else $error("alternate status read cleared interrupt");

    a_xfer_len_zero: assert property (cmd_start_q && use_mask_q[`SCD_PU_SC]
        |-> xfer_len_q == ((prm_sector_count_q == 8'h00) ? `SCD_SC_ZERO_LEN : {1'b0, prm_sector_count_q}))
        else $error("transfer length wrong");

    a_head_drive_only: assert property (seq_decode_sel ##0 (cls_sup && !is_pwr && !cls_dh_full)
        |=> cmd_start_q && (prm_head_q == 4'h0))
        else $error("head used by drive-only command");

    a_diag_unselected: assert property ((s_q.state == SCD_DECODE) && is_diag && !disk_emulation_mode && !sel
        |=> (s_q.state == SCD_IDLE) && !status_q[`SCD_BSY] && !$rose(irq_q))
        else $error("unselected card ran diagnostic");

    a_diag_slave_fail: assert property ((s_q.state == SCD_DIAG) && diag_done && disk_emulation_mode
        && is_master && slave_diag_fail |=> (error_q[7:4] == `SCD_DIAG_SLAVE_NIB) && irq_q)
        else $error("slave diagnostic failure not reported");

    // Start is a one-cycle handoff
    a_start_pulse: assert property (cmd_start_q |=> !cmd_start_q)
        else $error("start held too long");

    a_pwr_no_start: assert property (seq_decode_sel ##0 (cls_sup && is_pwr) |=> !cmd_start_q)
        else $error("power query started executor");

    // Unused registers reach the executor as zero
    a_unused_feat: assert property (cmd_start_q && !use_mask_q[`SCD_PU_FR] |-> prm_feature_q == 8'h00)
        else $error("unused feature passed");

    a_unused_number: assert property (cmd_start_q && !use_mask_q[`SCD_PU_SN] |-> prm_sector_number_q == 8'h00)
        else $error("unused sector number passed");

    a_lba_needs_mask: assert property (cmd_start_q && !use_mask_q[`SCD_PU_LBA] |-> !lba_mode_q)
        else $error("block addressing not allowed");

    a_drq_not_busy: assert property (status_q[`SCD_DRQ] |-> !status_q[`SCD_BSY])
        else $error("data request while busy");

    a_emu_diag_runs: assert property ((s_q.state == SCD_DECODE) && is_diag && disk_emulation_mode
        |=> (s_q.state == SCD_DIAG) && status_q[`SCD_BSY])
        else $error("emulation mode skipped diagnostic");

    a_diag_own_code: assert property ((s_q.state == SCD_DIAG) && diag_done
        && !(disk_emulation_mode && is_master && slave_diag_fail)
        |=> (error_q == $past(diag_self_code)) && irq_q && !status_q[`SCD_BSY])
        else $error("diagnostic code not reported");

    a_unsel_silent: assert property ((s_q.state == SCD_DECODE) && !sel && !is_diag
        |=> (status_q == `SCD_ST_DONE) && !cmd_start_q && !$rose(irq_q))
        else $error("other card command acted on");

endmodule

//--- hdl/scd_unused_guard.sv
// Holds no logic

//--- test/scd_exec_model.sv
// Command executor stand-in that answers each started command after a delay
`timescale 1ns/100ps
module scd_exec_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cmd_start_q,
    input wire logic [3:0] dly,
    input wire logic err_en,
    output logic exec_done,
    output logic exec_drq,
    output logic exec_err
);
    logic [3:0] cnt_q;
    logic run_q;

    // Falling-edge updates keep outputs clear of the sampling edge
    always @(negedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_q <= 1'b0;
            cnt_q <= 4'h0;
            exec_done <= 1'b0;
        end else begin
            exec_done <= run_q && cnt_q == 4'h0;
            if (cmd_start_q) begin
                run_q <= 1'b1;
                cnt_q <= dly;
            end else if (run_q) begin
                run_q <= cnt_q != 4'h0;
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    // Data wanted two cycles before done; error is garbage outside done
    assign exec_drq = run_q && cnt_q == 4'h1;
    assign exec_err = exec_done ? err_en : !err_en;
endmodule

//--- test/tb_storage_card_command_decoder.sv
// Self-checking bench of the storage card command decoder
`timescale 1ns/100ps
`include "scd_cfg.svh"
module tb_storage_card_command_decoder;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic tf_wr_stb = 1'b0;
    logic [2:0] tf_wr_addr = 3'h0;
    logic [7:0] tf_wr_data = 8'h00;
    logic status_rd_stb = 1'b0;
    logic alt_status_rd_stb = 1'b0;
    logic disk_emulation_mode = 1'b0;
    logic card_drive_id = 1'b0;
    logic is_master = 1'b1;
    logic power_sleep = 1'b0;
    logic skip_en = 1'b0;
    logic [7:0] skip_opcode = 8'h00;
    logic [7:0] exec_err_code = 8'h00;
    logic diag_done = 1'b0;
    logic [7:0] diag_self_code = 8'h01;
    logic slave_diag_fail = 1'b0;
    logic [3:0] dly = 4'h0;
    logic err_en = 1'b0;
    logic exec_done, exec_drq, exec_err, seen_drq;
    logic [7:0] status_q, error_q, sector_count_field_q, cmd_opcode_q;
    logic [7:0] prm_feature_q, prm_sector_count_q, prm_sector_number_q;
    logic irq_q, cmd_start_q, cmd_spec_q, prm_drive_q, lba_mode_q;
    logic [8:0] xfer_len_q;
    logic [15:0] prm_cylinder_q, lcy;
    logic [3:0] prm_head_q;
    logic [5:0] use_mask_q;
    logic [7:0] lf, lsc, lsn, ldh;
    int n_fail = 0;
    int num_checks = 0;
    // Entries {opcode, head used, specific, use mask}
    logic [15:0] sup [11] = '{16'hc8be, 16'hcabe, 16'h38be, 16'hcdbe, 16'hc0be, 16'h87be,
        16'h50ba, 16'h73bc, 16'hef51, 16'he352, 16'hec10};
    // Entries {opcode, feature}
    logic [15:0] bad [9] = '{16'he700, 16'hb900, 16'hb980, 16'hb981, 16'h0000, 16'h2200,
        16'h3300, 16'h3200, 16'hff00};

    always #4 clk_sys = ~clk_sys;

    scd_decoder dut (.clk_sys, .nrst, .tf_wr_stb, .tf_wr_addr, .tf_wr_data, .status_rd_stb,
        .alt_status_rd_stb, .disk_emulation_mode, .card_drive_id, .is_master, .power_sleep,
        .skip_en, .skip_opcode, .exec_done, .exec_drq, .exec_err, .exec_err_code, .diag_done,
        .diag_self_code, .slave_diag_fail, .status_q, .error_q, .sector_count_field_q, .irq_q,
        .cmd_start_q, .cmd_opcode_q, .cmd_spec_q, .prm_feature_q, .prm_sector_count_q,
        .xfer_len_q, .prm_sector_number_q, .prm_cylinder_q, .prm_drive_q, .prm_head_q,
        .lba_mode_q, .use_mask_q);

    scd_exec_model u_exec (.clk_sys, .nrst, .cmd_start_q, .dly, .err_en, .exec_done,
        .exec_drq, .exec_err);

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One task-file write; strobe spans exactly one rising edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        tf_wr_stb = 1'b1;
        tf_wr_addr = a;
        tf_wr_data = d;
        @(negedge clk_sys);
        tf_wr_stb = 1'b0;
    endtask

    // Parameters always go in before the opcode, never while busy
    task automatic load(input logic [7:0] f, s, n, input logic [15:0] c, input logic [7:0] h);
        {lf, lsc, lsn, lcy, ldh} = {f, s, n, c, h};
        wr(`SCD_TF_FEAT, f);
        wr(`SCD_TF_SC, s);
        wr(`SCD_TF_SN, n);
        wr(`SCD_TF_CYL_LO, c[7:0]);
        wr(`SCD_TF_CYL_HI, c[15:8]);
        wr(`SCD_TF_DH, h);
    endtask

    // Opcode write, then step to the cycle where the decode lands
    task automatic cmd(input logic [7:0] op);
        wr(`SCD_TF_CMD, op);
        chk("busy after opcode", `SCD_ST_BUSY, status_q);
        @(negedge clk_sys);
    endtask

    task automatic rd_st(input logic alt);
        @(negedge clk_sys);
        status_rd_stb = !alt;
        alt_status_rd_stb = alt;
        @(negedge clk_sys);
        status_rd_stb = 1'b0;
        alt_status_rd_stb = 1'b0;
    endtask

    // Bounded wait for completion, then the interrupt is read away
    task automatic done(input logic [7:0] st, er, input logic ce);
        int i;
        seen_drq = 1'b0;
        for (i = 0; i < 40 && (status_q === `SCD_ST_BUSY || status_q === `SCD_ST_DRQ); i++) begin
            @(negedge clk_sys);
            if (status_q === `SCD_ST_DRQ) seen_drq = 1'b1;
        end
        chk("final status", st, status_q);
        if (ce) chk("error reg", er, error_q);
        chk("irq raised", 1, irq_q);
        rd_st(1'b0);
        chk("irq after read", 0, irq_q);
    endtask

    task automatic prm(input logic [5:0] m, input logic f, input logic s);
        chk("start", 1, cmd_start_q);
        chk("use mask", m, use_mask_q);
        chk("specific", s, cmd_spec_q);
        chk("feature", m[0] ? lf : 8'h00, prm_feature_q);
        chk("count", m[1] ? lsc : 8'h00, prm_sector_count_q);
        chk("length", !m[1] ? 9'h000 : lsc == 8'h00 ? `SCD_SC_ZERO_LEN : {1'b0, lsc}, xfer_len_q);
        chk("number", m[2] ? lsn : 8'h00, prm_sector_number_q);
        chk("cylinder", m[3] ? lcy : 16'h0000, prm_cylinder_q);
        chk("drive", ldh[4], prm_drive_q);
        chk("head", f ? ldh[3:0] : 4'h0, prm_head_q);
        chk("lba", m[5] & ldh[6], lba_mode_q);
    endtask

    // Self test; an expected code of zero means the command is dropped
    task automatic diag(input logic emu, mst, drv, fl, input logic [7:0] code, exp);
        disk_emulation_mode = emu;
        is_master = mst;
        slave_diag_fail = fl;
        diag_self_code = code;
        wr(`SCD_TF_DH, {3'b111, drv, 4'h0});
        cmd(`SCD_OP_DIAG);
        if (exp === 8'h00) begin
            chk("diag dropped", `SCD_ST_DONE, status_q);
            chk("diag no irq", 0, irq_q);
        end else begin
            chk("diag wait", `SCD_ST_BUSY, status_q);
            @(negedge clk_sys);
            diag_done = 1'b1;
            @(negedge clk_sys);
            diag_done = 1'b0;
            done(`SCD_ST_DONE, exp, 1'b1);
        end
    endtask

    initial begin
        repeat (8) @(negedge clk_sys);
        chk("status in reset", 8'h00, status_q);
        nrst = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("ready", `SCD_ST_DONE, status_q);
        // Power query: both opcodes, both power states, stale count loaded
        for (int i = 0; i < 4; i++) begin
            power_sleep = i[1];
            load(8'h5a, 8'h33, 8'h44, 16'h5566, 8'ha0);
            cmd(i[0] ? `SCD_OP_PWR_B : `SCD_OP_PWR_A);
            chk("no start", 0, cmd_start_q);
            chk("power answer", i[1] ? `SCD_PWR_SLEEP_SC : `SCD_PWR_IDLE_SC, sector_count_field_q);
            rd_st(1'b1);
            chk("irq after alt read", 1, irq_q);
            done(`SCD_ST_DONE, `SCD_ERR_NONE, 1'b1);
        end
        foreach (bad[i]) begin
            load(bad[i][7:0], 8'h01, 8'h02, 16'h0304, 8'he0);
            cmd(bad[i][15:8]);
            chk("no start", 0, cmd_start_q);
            done(`SCD_ST_ABORT, `SCD_ERR_ABRT, 1'b1);
        end
        // Count boundaries, head 15 down, delay 0 up, one executor error
        foreach (sup[i]) begin
            dly = i[3:0];
            err_en = i == 4;
            exec_err_code = {4'h4, i[3:0]};
            load(8'haa, i % 3 == 0 ? 8'h00 : i % 3 == 1 ? 8'hff : 8'h01, 8'h12, 16'h3456,
                {1'b1, i[0], 2'b10, 4'hf - i[3:0]});
            cmd(sup[i][15:8]);
            chk("opcode", sup[i][15:8], cmd_opcode_q);
            prm(sup[i][5:0], sup[i][7], sup[i][6]);
            done(i == 4 ? `SCD_ST_ABORT : `SCD_ST_DONE, 8'h44, i == 4);
            if (i != 0) chk("drq seen", 1, seen_drq);
        end
        err_en = 1'b0;
        // Other drive addressed: no start, no interrupt
        card_drive_id = 1'b1;
        load(8'h00, 8'h00, 8'h00, 16'h0000, 8'ha0);
        cmd(8'hec);
        chk("dropped start", 0, cmd_start_q);
        chk("dropped status", `SCD_ST_DONE, status_q);
        chk("dropped irq", 0, irq_q);
        load(8'h01, 8'h02, 8'h03, 16'h0405, 8'hb9);
        cmd(8'h20);
        prm(6'h3e, 1'b1, 1'b0);
        done(`SCD_ST_DONE, 8'h00, 1'b0);
        skip_en = 1'b1;
        skip_opcode = 8'he4;
        cmd(8'he4);
        chk("skip no start", 0, cmd_start_q);
        done(`SCD_ST_DONE, `SCD_ERR_NONE, 1'b1);
        skip_en = 1'b0;
        diag(1'b0, 1'b1, 1'b1, 1'b1, 8'h03, 8'h03);
        diag(1'b0, 1'b1, 1'b0, 1'b0, 8'h01, 8'h00);
        diag(1'b1, 1'b1, 1'b0, 1'b1, 8'h02, {`SCD_DIAG_SLAVE_NIB, 4'h2});
        diag(1'b1, 1'b0, 1'b0, 1'b1, 8'h05, 8'h05);
        diag(1'b1, 1'b1, 1'b1, 1'b0, 8'h01, 8'h01);
        print_verdict();
    end

    // Whole run needs about six hundred cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        print_verdict();
    end
endmodule
